// ### pkg/snb_pkg.sv
// Word addresses, bit positions and layout constants of the status bank.
package snb_pkg;
  localparam logic [15:0] AUX_PORT_EN       = 16'h00ca;
  localparam logic [15:0] AUX_CODE_FIRST    = 16'h00cb;
  localparam logic [15:0] AUX_CODE_LAST     = 16'h00d2;
  localparam logic [15:0] AUX_PORT_ERR      = 16'h00db;
  localparam logic [15:0] AUX_UNIT_INIT     = 16'h012e;
  localparam logic [15:0] AUX_DUP_FATAL     = 16'h0191;
  localparam logic [15:0] AUX_UNIT_ERR      = 16'h0192;
  localparam logic [15:0] AUX_DUP_UNITS     = 16'h019a;
  localparam logic [15:0] AUX_BUS_ERR_UNITS = 16'h01a1;
  localparam logic [15:0] AUX_SET_ERR_UNITS = 16'h01ab;
  localparam logic [15:0] AUX_RESTART       = 16'h01f5;

  localparam logic [3:0]  BIT_DUP_FATAL     = 4'hd;
  localparam logic [3:0]  BIT_SET_ERR       = 4'h3;
  localparam logic [3:0]  BIT_BUS_ERR       = 4'h7;

  localparam logic [15:0] IO_AREA_BASE      = 16'h05dc;
  localparam logic [15:0] UNIT_WORDS        = 16'h0019;

  localparam logic [4:0]  OFF_ERR_DATA      = 5'h01;
  localparam logic [4:0]  OFF_MEMB_FIRST    = 5'h02;
  localparam logic [4:0]  OFF_MEMB_LAST     = 5'h05;
  localparam logic [4:0]  OFF_LOCAL_ADDR    = 5'h06;
  localparam logic [4:0]  OFF_POLL_ADDR     = 5'h07;
  localparam logic [4:0]  OFF_LINK_FIRST    = 5'h08;
  localparam logic [4:0]  OFF_LINK_LAST     = 5'h17;
  localparam logic [4:0]  OFF_POWER         = 5'h18;

  localparam logic [3:0]  LINK_ACTIVE_BIT   = 4'hf;
  localparam logic [3:0]  LAST_LINK_WORD    = 4'hf;
  localparam int          NODES             = 62;
  localparam int          NODE_FLAGS        = 4;
  localparam logic [15:0] RESET_WORD        = 16'h0000;
endpackage

// ### hw/snb_flag_bank.sv
// Sticky flag vector: bits set by hardware, cleared by a clear vector.
module snb_flag_bank #(
  parameter int W = 16
) (
  input  wire logic         I_CLK,
  input  wire logic         I_ARST_N,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] q;
  } snb_flag_t;

  snb_flag_t st;
  snb_flag_t next_st;

  // A set arriving with its clear wins, so no event is lost.
  always_comb begin
    next_st   = st;
    next_st.q = (st.q & ~i_clr) | i_set;
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_q = st.q;
endmodule

// ### hw/snb_hold_reg.sv
// Status snapshot that refreshes only while its load input is high.
module snb_hold_reg #(
  parameter int W = 16
) (
  input  wire logic         I_CLK,
  input  wire logic         I_ARST_N,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_data,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] q;
  } snb_hold_t;

  snb_hold_t st;
  snb_hold_t next_st;

  always_comb begin
    next_st = st;
    if (i_load) begin
      next_st.q = i_data;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_q = st.q;
endmodule

// ### hw/snb_status_bank.sv
// Auxiliary flag words and per-unit bit-area block of the link unit.
module snb_status_bank
  import snb_pkg::*;
#(
  parameter bit OPTICAL = 1'b1
) (
  input  wire logic                     I_CLK,
  input  wire logic                     I_ARST_N,
  input  wire logic                     I_RD,
  input  wire logic                     I_WR,
  input  wire logic                     I_AUX,
  input  wire logic [15:0]              I_ADDR,
  input  wire logic [15:0]              I_WDATA,
  output logic      [15:0]              O_RDATA,
  output logic                          O_RVALID,
  input  wire logic [3:0]               I_UNIT_NO,
  input  wire logic [7:0]               I_PORT_READY,
  input  wire logic                     I_COMP_VALID,
  input  wire logic [2:0]               I_COMP_PORT,
  input  wire logic [15:0]              I_COMP_CODE,
  input  wire logic                     I_COMP_ERR,
  input  wire logic [15:0]              I_UNIT_INIT,
  input  wire logic                     I_CFG_MISMATCH,
  input  wire logic [3:0]               I_CFG_UNIT,
  input  wire logic                     I_PARITY_ERR,
  input  wire logic [3:0]               I_PARITY_UNIT,
  input  wire logic [15:0]              I_DUP_UNITS,
  input  wire logic [15:0]              I_RESTART_DONE,
  output logic      [15:0]              O_RESTART,
  input  wire logic [15:0]              I_ERROR_DATA,
  input  wire logic [15:0]              I_POWER_STATUS,
  input  wire logic                     I_LOCAL_ONLINE,
  input  wire logic [snb_pkg::NODES-1:0] I_NODE_PRESENT,
  input  wire logic [7:0]               I_LOCAL_NET,
  input  wire logic [7:0]               I_LOCAL_NODE,
  input  wire logic [7:0]               I_LOCAL_UNIT,
  input  wire logic [7:0]               I_POLL_NODE,
  input  wire logic                     I_LINK_ACTIVE,
  input  wire logic [snb_pkg::NODES*snb_pkg::NODE_FLAGS-1:0] I_LINK_FLAGS
);
  import snb_pkg::*;

  typedef struct packed {
    logic [15:0]       rdata;
    logic              rvalid;
    logic [7:0][15:0]  code;
    logic [7:0]        port_err;
  } snb_state_t;

  snb_state_t st;
  snb_state_t next_st;

  logic [15:0]             set_err_q;
  logic [15:0]             bus_err_q;
  logic [15:0]             dup_q;
  logic [15:0]             restart_q;
  logic [15:0]             restart_set;
  logic [NODES-1:0]        memb_q;
  logic [NODES-1:0]        memb_next;
  logic [NODES-1:0]        local_mask;
  logic                    memb_load;
  logic [NODES*NODE_FLAGS-1:0] link_q;
  logic [15:0]             unit_base;
  logic [15:0]             unit_off;
  logic                    in_unit;
  logic [63:0]             memb_pad;
  logic [255:0]            link_pad;

  function automatic logic [15:0] one_hot16(input logic [3:0] idx);
    one_hot16 = 16'h0001 << idx;
  endfunction

  // Unmatched, mismatched units are latched until reset.
  snb_flag_bank #(.W(16)) u_set_err (
    .I_CLK   (I_CLK),
    .I_ARST_N(I_ARST_N),
    .i_set   (I_CFG_MISMATCH ? one_hot16(I_CFG_UNIT) : 16'h0000),
    .i_clr   (16'h0000),
    .o_q     (set_err_q)
  );

  snb_flag_bank #(.W(16)) u_bus_err (
    .I_CLK   (I_CLK),
    .I_ARST_N(I_ARST_N),
    .i_set   (I_PARITY_ERR ? one_hot16(I_PARITY_UNIT) : 16'h0000),
    .i_clr   (16'h0000),
    .o_q     (bus_err_q)
  );

  snb_flag_bank #(.W(16)) u_dup (
    .I_CLK   (I_CLK),
    .I_ARST_N(I_ARST_N),
    .i_set   (I_DUP_UNITS),
    .i_clr   (16'h0000),
    .o_q     (dup_q)
  );

  // Writes only set restart bits; the unit's done pulse clears them.
  assign restart_set = (I_WR && I_AUX && I_ADDR == AUX_RESTART) ?
                       I_WDATA : 16'h0000;

  snb_flag_bank #(.W(16)) u_restart (
    .I_CLK   (I_CLK),
    .I_ARST_N(I_ARST_N),
    .i_set   (restart_set),
    .i_clr   (I_RESTART_DONE),
    .o_q     (restart_q)
  );

  assign O_RESTART = restart_q;

  // Node n sits at bit n-1; an out-of-range local node masks nothing.
  assign local_mask = (I_LOCAL_NODE >= 8'h01 && I_LOCAL_NODE <= 8'h3e) ?
                      (NODES'(1) << (I_LOCAL_NODE - 8'h01)) : '0;
  assign memb_next  = I_LOCAL_ONLINE ? I_NODE_PRESENT :
                      (memb_q & ~local_mask);
  assign memb_load  = I_LOCAL_ONLINE | (|(memb_q & local_mask));

  snb_hold_reg #(.W(NODES)) u_memb (
    .I_CLK   (I_CLK),
    .I_ARST_N(I_ARST_N),
    .i_load  (memb_load),
    .i_data  (memb_next),
    .o_q     (memb_q)
  );

  snb_hold_reg #(.W(NODES*NODE_FLAGS)) u_link (
    .I_CLK   (I_CLK),
    .I_ARST_N(I_ARST_N),
    .i_load  (I_LINK_ACTIVE),
    .i_data  (I_LINK_FLAGS),
    .o_q     (link_q)
  );

  // Top bits of the padded vectors have no node behind them.
  assign memb_pad = {2'b00, memb_q};
  assign link_pad = {8'h00, link_q};

  // Word views of the held vectors, in the order the CPU reads them.
  logic [3:0][15:0]  memb_word;
  logic [15:0][15:0] link_word;

  for (genvar w = 0; w < 4; w++) begin : g_memb_word
    assign memb_word[w] = memb_pad[16*w +: 16];
  end

  // The last link word carries the live local flag in its top bit, so a
  // frozen table never hides that the local link has stopped.
  for (genvar w = 0; w < 16; w++) begin : g_link_word
    if (w == LAST_LINK_WORD) begin : g_tail
      assign link_word[w] = {I_LINK_ACTIVE, link_pad[16*w +: 15]};
    end else begin : g_body
      assign link_word[w] = link_pad[16*w +: 16];
    end
  end

  assign unit_base = IO_AREA_BASE + UNIT_WORDS * {12'h000, I_UNIT_NO};
  assign unit_off  = I_ADDR - unit_base;
  assign in_unit   = !I_AUX && I_ADDR >= unit_base &&
                     unit_off < UNIT_WORDS;

  // Word map as the CPU sees it. Auxiliary words, with I_AUX high:
  //   port_enabled_flags        live ready level of ports 0 to 7.
  //   port_response_codes       latest code, one word per port.
  //   port_execute_error_flags  error of the latest completion per port.
  //   unit_initializing_flags   live init level per unit number.
  //   duplicate_number_fatal    bit 13, any duplicated unit number.
  //   unit_setting_and_error    bit 3 setting error, bit 7 parity error.
  //   duplicated_unit_bits      duplicated unit numbers, sticky.
  //   bus_error_unit_bits       units with a parity error, sticky.
  //   setting_error_unit_bits   units unlike the configuration, sticky.
  //   unit_restart_bits         restart requests, cleared when done.
  // Bit-area words of this unit's block, with I_AUX low:
  //   reserved_word             reads zero.
  //   error_data_word           live error data.
  //   membership words          node n at bit n-1 across four words.
  //   address words             network, node, unit and polling node.
  //   link status words         four node nibbles per word, table order.
  //   power_supply_status       live, zero on the coaxial variant.
  // Every other word reads zero, including other units' blocks.
  always_comb begin
    logic [4:0]  off;
    logic [3:0]  lidx;
    logic [1:0]  midx;
    logic [15:0] word;
    off  = unit_off[4:0];
    lidx = 4'(off - OFF_LINK_FIRST);
    midx = 2'(off - OFF_MEMB_FIRST);
    word = RESET_WORD;

    next_st        = st;
    next_st.rvalid = I_RD;

    if (I_COMP_VALID) begin
      next_st.code[I_COMP_PORT]     = I_COMP_CODE;
      next_st.port_err[I_COMP_PORT] = I_COMP_ERR;
    end

    if (I_AUX) begin
      unique case (I_ADDR) inside
        [AUX_CODE_FIRST:AUX_CODE_LAST]: begin
          word = st.code[3'(I_ADDR - AUX_CODE_FIRST)];
        end
        AUX_PORT_EN: begin
          word = {8'h00, I_PORT_READY};
        end
        AUX_PORT_ERR: begin
          word = {8'h00, st.port_err};
        end
        AUX_UNIT_INIT: begin
          word = I_UNIT_INIT;
        end
        AUX_DUP_FATAL: begin
          word[BIT_DUP_FATAL] = |dup_q;
        end
        AUX_UNIT_ERR: begin
          word[BIT_SET_ERR] = |set_err_q;
          word[BIT_BUS_ERR] = |bus_err_q;
        end
        AUX_DUP_UNITS: begin
          word = dup_q;
        end
        AUX_BUS_ERR_UNITS: begin
          word = bus_err_q;
        end
        AUX_SET_ERR_UNITS: begin
          word = set_err_q;
        end
        AUX_RESTART: begin
          word = restart_q;
        end
        default: begin
          // Unmapped auxiliary words read as zero.
          word = RESET_WORD;
        end
      endcase
    end else if (in_unit) begin
      unique case (off) inside
        OFF_ERR_DATA: begin
          word = I_ERROR_DATA;
        end
        [OFF_MEMB_FIRST:OFF_MEMB_LAST]: begin
          word = memb_word[midx];
        end
        OFF_LOCAL_ADDR: begin
          word = {I_LOCAL_NET, I_LOCAL_NODE};
        end
        OFF_POLL_ADDR: begin
          word = {I_LOCAL_UNIT, I_POLL_NODE};
        end
        [OFF_LINK_FIRST:OFF_LINK_LAST]: begin
          word = link_word[lidx];
        end
        OFF_POWER: begin
          // The coaxial variant has no power supply word.
          word = OPTICAL ? I_POWER_STATUS : RESET_WORD;
        end
        default: begin
          // Reserved word and anything unlisted read as zero.
          word = RESET_WORD;
        end
      endcase
    end

    // Read data holds its last value between reads.
    if (I_RD) begin
      next_st.rdata = word;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign O_RDATA  = st.rdata;
  assign O_RVALID = st.rvalid;
endmodule

// ### dv/snb_status_bank_properties.sv
// Port-level assertions for the status bank.
module snb_status_bank_properties (
  input  wire logic        I_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_RD,
  input  wire logic        I_WR,
  input  wire logic        I_AUX,
  input  wire logic [15:0] I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic [15:0] O_RDATA,
  input  wire logic        O_RVALID,
  input  wire logic [3:0]  I_UNIT_NO,
  input  wire logic [7:0]  I_PORT_READY,
  input  wire logic [15:0] I_RESTART_DONE,
  input  wire logic [15:0] O_RESTART,
  input  wire logic        I_LINK_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ns;
  import snb_pkg::*;
  logic [15:0] base;
  logic        io_rd;
  logic        rs_wr;
  assign base  = IO_AREA_BASE + UNIT_WORDS * {12'h000, I_UNIT_NO};
  assign io_rd = I_RD && !I_AUX;
  assign rs_wr = I_WR && I_AUX && I_ADDR == AUX_RESTART;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  read_answer_a: assert property (I_RD |=> O_RVALID)
    else $error("read not answered");
  port_enable_a: assert property (I_RD && I_AUX && I_ADDR == AUX_PORT_EN
    |=> O_RDATA[7:0] == $past(I_PORT_READY)) else $error("port flags");
  restart_set_a: assert property (rs_wr
    |=> (O_RESTART & $past(I_WDATA)) == $past(I_WDATA)) else $error("set");
  restart_done_a: assert property (I_RESTART_DONE != 16'h0000 && !I_WR
    |=> (O_RESTART & $past(I_RESTART_DONE)) == 16'h0000) else $error("done");
  restart_hold_a: assert property (!rs_wr && I_RESTART_DONE == 16'h0000
    |=> $stable(O_RESTART)) else $error("restart bits moved");
  rsvd_zero_a: assert property (io_rd && I_ADDR == base
    |=> O_RDATA == 16'h0000) else $error("reserved word");
  memb_tail_a: assert property (io_rd && I_ADDR == base + 16'h0005
    |=> O_RDATA[15:14] == 2'h0) else $error("membership tail");
  link_flag_a: assert property (io_rd && I_ADDR == base + 16'h0017
    |=> O_RDATA[15] == $past(I_LINK_ACTIVE)) else $error("link flag");
  cover property (rs_wr);
  cover property (I_RESTART_DONE != 16'h0000);
  cover property (io_rd && I_ADDR == base + 16'h0017 && !I_LINK_ACTIVE);
endmodule
bind snb_status_bank snb_status_bank_properties
  i_snb_status_bank_properties (
  .I_CLK         (I_CLK),
  .I_ARST_N      (I_ARST_N),
  .I_RD          (I_RD),
  .I_WR          (I_WR),
  .I_AUX         (I_AUX),
  .I_ADDR        (I_ADDR),
  .I_WDATA       (I_WDATA),
  .O_RDATA       (O_RDATA),
  .O_RVALID      (O_RVALID),
  .I_UNIT_NO     (I_UNIT_NO),
  .I_PORT_READY  (I_PORT_READY),
  .I_RESTART_DONE(I_RESTART_DONE),
  .O_RESTART     (O_RESTART),
  .I_LINK_ACTIVE (I_LINK_ACTIVE)
);

// ### dv/snb_restart_agent.sv
// Plug-in unit model that finishes a requested restart some cycles later.
module snb_restart_agent #(
  parameter int DELAY = 6
) (
  input  wire logic        I_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic [15:0] i_restart,
  output logic      [15:0] o_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // The done pulse is late on purpose, so the bits are seen standing.
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cnt    <= 0;
      o_done <= 16'h0000;
    end else begin
      o_done <= 16'h0000;
      cnt    <= (i_restart != 16'h0000 && o_done == 16'h0000) ? cnt + 1 : 0;
      if (cnt == DELAY) begin
        o_done <= i_restart;
        cnt    <= 0;
      end
    end
  end
endmodule

// ### dv/snb_status_bank_tb_top.sv
// Self-checking bench for the status bank.
module snb_status_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import snb_pkg::*;
  logic                        clk, arst_n, rd, wr, aux, cv, cerr, cfg, par;
  logic                        online, lact, rvalid;
  logic [15:0]                 addr, wdata, rdata, rst, done, code, init;
  logic [15:0]                 dup, edata, pwr, base;
  logic [7:0]                  ready, net, node, unit, poll;
  logic [3:0]                  cfg_unit, par_unit, unit_no;
  logic [2:0]                  cport;
  logic [NODES-1:0]            present;
  logic [NODES*NODE_FLAGS-1:0] flags;
  int                          fails, checks_done;
  snb_status_bank i_snb_status_bank (.I_CLK(clk), .I_ARST_N(arst_n),
    .I_RD(rd), .I_WR(wr), .I_AUX(aux), .I_ADDR(addr), .I_WDATA(wdata),
    .O_RDATA(rdata), .O_RVALID(rvalid), .I_UNIT_NO(unit_no),
    .I_PORT_READY(ready), .I_COMP_VALID(cv), .I_COMP_PORT(cport),
    .I_COMP_CODE(code), .I_COMP_ERR(cerr), .I_UNIT_INIT(init),
    .I_CFG_MISMATCH(cfg), .I_CFG_UNIT(cfg_unit), .I_PARITY_ERR(par),
    .I_PARITY_UNIT(par_unit), .I_DUP_UNITS(dup), .I_RESTART_DONE(done),
    .O_RESTART(rst), .I_ERROR_DATA(edata), .I_POWER_STATUS(pwr),
    .I_LOCAL_ONLINE(online), .I_NODE_PRESENT(present), .I_LOCAL_NET(net),
    .I_LOCAL_NODE(node), .I_LOCAL_UNIT(unit), .I_POLL_NODE(poll),
    .I_LINK_ACTIVE(lact), .I_LINK_FLAGS(flags));
  snb_restart_agent i_snb_restart_agent (.I_CLK(clk), .I_ARST_N(arst_n),
    .i_restart(rst), .o_done(done));
  always #50 clk = ~clk;
  task automatic step();
    @(posedge clk);
    #10;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd16(input logic a, input logic [15:0] ad, exp);
    step();
    {rd, aux, addr} = {2'b11 & {1'b1, a}, ad};
    step();
    rd = 1'b0;
    cmp({15'h0000, rvalid}, 16'h0001);
    cmp(rdata, exp);
  endtask
  task automatic wr16(input logic [15:0] ad, input logic [15:0] d);
    step();
    {wr, aux, addr, wdata} = {2'b11, ad, d};
    step();
    wr = 1'b0;
  endtask
  task automatic end_sim();
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  initial begin
    {clk, arst_n, rd, wr, aux, cv, cerr, cfg, par, lact} = 10'h000;
    {addr, wdata, code, init, dup, edata, pwr} = 112'h0;
    {ready, net, node, unit, poll, cport, cfg_unit, par_unit} = 51'h0;
    {fails, checks_done} = 64'h0;
    online = 1'b1;
    unit_no = 4'h2;
    present = {NODES{1'b1}};
    flags = {31{8'h21}};
    base = IO_AREA_BASE + UNIT_WORDS * {12'h000, unit_no};
    repeat (20) @(posedge clk);
    #10 arst_n = 1'b1;
    rd16(1'b1, AUX_RESTART, 16'h0000);
    {ready, init} = {8'ha5, 16'h8001};
    rd16(1'b1, AUX_PORT_EN, 16'h00a5);
    rd16(1'b1, AUX_UNIT_INIT, 16'h8001);
    for (int p = 0; p < 8; p++) begin
      step();
      {cv, cport, code, cerr} = {1'b1, 3'(p), 16'h0100 + 16'(p), p[0]};
    end
    step();
    cv = 1'b0;
    for (int p = 0; p < 8; p++) begin
      rd16(1'b1, AUX_CODE_FIRST + 16'(p), 16'h0100 + 16'(p));
    end
    rd16(1'b1, AUX_PORT_ERR, 16'h00aa);
    step();
    {cfg, cfg_unit, par, par_unit, dup} = {5'h15, 5'h1f, 16'h0006};
    step();
    {cfg, par, dup} = 18'h0;
    rd16(1'b1, AUX_SET_ERR_UNITS, 16'h0020);
    rd16(1'b1, AUX_BUS_ERR_UNITS, 16'h8000);
    rd16(1'b1, AUX_UNIT_ERR, 16'h0088);
    rd16(1'b1, AUX_DUP_UNITS, 16'h0006);
    rd16(1'b1, AUX_DUP_FATAL, 16'h2000);
    step();
    arst_n = 1'b0;
    repeat (2) step();
    arst_n = 1'b1;
    rd16(1'b1, AUX_SET_ERR_UNITS, 16'h0000);
    rd16(1'b1, AUX_UNIT_ERR, 16'h0000);
    wr16(AUX_PORT_EN, 16'hffff);
    rd16(1'b1, AUX_RESTART, 16'h0000);
    wr16(AUX_RESTART, 16'h0011);
    rd16(1'b1, AUX_RESTART, 16'h0011);
    for (int i = 0; i < 40 && rst !== 16'h0000; i++) step();
    rd16(1'b1, AUX_RESTART, 16'h0000);
    {edata, pwr, net, node, unit, poll} = 64'h5a5a_c3c3_1205_3407;
    rd16(1'b1, 16'h0000, 16'h0000);
    rd16(1'b0, IO_AREA_BASE + 16'h0001, 16'h0000);
    rd16(1'b0, base, 16'h0000);
    rd16(1'b0, base + 16'h0001, 16'h5a5a);
    rd16(1'b0, base + 16'h0018, 16'hc3c3);
    rd16(1'b0, base + 16'h0006, 16'h1205);
    rd16(1'b0, base + 16'h0007, 16'h3407);
    rd16(1'b0, base + 16'h0005, 16'h3fff);
    {online, present} = {1'b0, {NODES{1'b0}}};
    rd16(1'b0, base + 16'h0002, 16'hffef);
    online = 1'b1;
    rd16(1'b0, base + 16'h0002, 16'h0000);
    lact = 1'b1;
    rd16(1'b0, base + 16'h0008, 16'h2121);
    rd16(1'b0, base + 16'h0017, 16'h8021);
    {lact, flags} = {1'b0, {31{8'h43}}};
    rd16(1'b0, base + 16'h0008, 16'h2121);
    rd16(1'b0, base + 16'h0017, 16'h0021);
    unit_no = 4'hf;
    base = IO_AREA_BASE + UNIT_WORDS * {12'h000, unit_no};
    rd16(1'b0, base + 16'h0006, 16'h1205);
    rd16(1'b0, base - 16'h0013, 16'h0000);
    end_sim();
  end
endmodule
